// ---- common/gmb_pkg.sv ----
// Function
// RULE1 - device raises config-change interrupt to start any resize
// RULE2 - requested above held wants more pages; below means balloon holds too much
// RULE3 - inflate array holds address/4096 as 32-bit entries on grow queue
// RULE4 - deflate array of ballooned pages posted on shrink queue
// RULE5 - driver announces reclaimed pages on the shrink queue
// RULE6 - with notify-before-reuse, driver waits for shrink descriptor return
// RULE7 - without notify-before-reuse, device tolerates early page reuse
// RULE8 - driver writes held count after each inflate or deflate
// RULE9 - driver should inflate when requested exceeds held
// RULE10 - driver may deflate when requested is below held
// RULE11 - driver primes report queue with one empty buffer and notifies
// RULE12 - device starts statistics request by returning held buffer, interrupting
// RULE13 - driver discards used buffer, posts fresh statistics buffer, notifies
// RULE14 - device consumes statistics and keeps buffer for the next request
// RULE15 - record is 16-bit tag then 64-bit value, packed back to back
// RULE16 - every statistic optional; unsupported ones should be omitted
// RULE17 - statistics little-endian, guest native order in legacy mode
// RULE18 - tags 0 swap in, 1 swap out, 2 major faults
// RULE19 - tags 3 minor faults, 4 free bytes, 5 total bytes
// RULE20 - requested and held counts are 32-bit, always little-endian
// RULE21 - queue 0 grow, 1 shrink, 2 report only with statistics feature
// RULE22 - feature bit 0 notify-before-reuse, bit 1 report queue present
// RULE23 - descriptor returned used only after all its frames are processed
package gmb_pkg;
  localparam logic [7:0] GMB_REG_REQ = 8'h00;
  localparam logic [7:0] GMB_REG_HELD = 8'h04;
  localparam logic [7:0] GMB_REG_FEAT = 8'h08;
  localparam logic [7:0] GMB_REG_STATUS = 8'h0c;
  localparam logic [7:0] GMB_REG_CTRL = 8'h10;
  localparam logic [7:0] GMB_REG_NOTIFY = 8'h14;
  localparam logic [7:0] GMB_REG_FRAME = 8'h18;
  localparam logic [7:0] GMB_REG_DONE = 8'h1c;
  localparam logic [7:0] GMB_REG_STAT_TAG = 8'h20;
  localparam logic [7:0] GMB_REG_STAT_LO = 8'h24;
  localparam logic [7:0] GMB_REG_STAT_HI = 8'h28;
  localparam logic [7:0] GMB_REG_FRAMES = 8'h2c;
  localparam logic [7:0] GMB_REG_STAT_BASE = 8'h40;
  localparam int GMB_FEAT_REUSE_BIT = 0;
  localparam int GMB_FEAT_REPORT_BIT = 1;
  localparam logic [1:0] GMB_Q_GROW = 2'h0;
  localparam logic [1:0] GMB_Q_SHRINK = 2'h1;
  localparam logic [1:0] GMB_Q_REPORT = 2'h2;
  localparam logic [2:0] GMB_NUM_TAGS = 3'h6;
  localparam logic [31:0] GMB_PAGE_BYTES = 32'h0000_1000;
  localparam logic [31:0] GMB_REQ_RESET = 32'h0000_0000;
  localparam logic [1:0] GMB_RESP_OKAY = 2'b00;
  localparam logic [1:0] GMB_RESP_SLVERR = 2'b10;
  typedef enum logic [2:0] {
    GMB_IDLE, GMB_GROW, GMB_SHRINK, GMB_RET
  } gmb_q_state_t;
  typedef struct packed {
    logic [15:0] tag;
    logic [63:0] value;
  } gmb_stat_t;
endpackage : gmb_pkg

// ---- core/gmb_balloon.sv ----
`timescale 1ns/1ps
`default_nettype none
module gmb_balloon
  import gmb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic config_irq_q,
  output logic report_irq_q
);
  // register state
  logic [31:0] req_q, held_q, frames_q;
  logic [1:0] feat_q;
  logic legacy_q;
  logic report_held_q, report_buf_q;
  logic [1:0] used_q;
  gmb_q_state_t st_q;
  logic [31:0] left_q;
  gmb_stat_t last_q;
  logic [63:0] stats_q [0:5];
  logic aw_q, w_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  function automatic logic [31:0] merge(input logic [31:0] o,
      input logic [31:0] n, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // legacy fields in guest order; modelled as byte reversal
  function automatic logic [31:0] fix32(input logic [31:0] v, input logic l);
    return l ? {v[7:0], v[15:8], v[23:16], v[31:24]} : v;
  endfunction : fix32

  logic wr_go;
  logic [31:0] wv;
  logic [31:0] wfix;
  assign wr_go = aw_q && w_q && !s_axi_bvalid;
  assign wv = merge(32'h0000_0000, wdata_q, wstrb_q);
  // statistics word in device order; a function result cannot be sliced
  assign wfix = fix32(wv, legacy_q);

  // address and data latch independently, in either order
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_q <= 1'b0;
      end
    end
  end

  // ready only while the holding slot is empty
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= GMB_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_q && !(s_axi_wvalid && s_axi_wready);
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q > GMB_REG_FRAMES) ? GMB_RESP_SLVERR
                                                   : GMB_RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // configuration: any write to the requested count raises config interrupt
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      req_q <= GMB_REQ_RESET;
      held_q <= 32'h0000_0000;
      feat_q <= 2'b00;
      legacy_q <= 1'b0;
      config_irq_q <= 1'b0;
    end else begin
      if (wr_go && awaddr_q == GMB_REG_REQ) begin
        req_q <= merge(req_q, wdata_q, wstrb_q);
        config_irq_q <= 1'b1; // RULE1
      end else if (wr_go && awaddr_q == GMB_REG_STATUS && wv[0]) begin
        config_irq_q <= 1'b0;
      end
      if (wr_go && awaddr_q == GMB_REG_HELD) begin
        held_q <= merge(held_q, wdata_q, wstrb_q); // RULE8 RULE20
      end
      if (wr_go && awaddr_q == GMB_REG_FEAT) begin
        feat_q <= wv[1:0]; // RULE22
        legacy_q <= wv[31];
      end
    end
  end

  // descriptor engine: frames counted down before used return
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_q <= GMB_IDLE;
      left_q <= 32'h0000_0000;
      frames_q <= 32'h0000_0000;
      used_q <= 2'b00;
    end else begin
      case (st_q)
        GMB_IDLE: begin
          if (wr_go && awaddr_q == GMB_REG_NOTIFY && wv[31:16] != 16'h0) begin
            left_q <= {16'h0000, wv[31:16]};
            used_q <= 2'b00;
            if (wv[1:0] == GMB_Q_GROW) begin
              st_q <= GMB_GROW; // RULE21
            end else if (wv[1:0] == GMB_Q_SHRINK) begin
              st_q <= GMB_SHRINK; // RULE5
            end
          end
        end
        GMB_GROW, GMB_SHRINK: begin
          // each entry is a 4 KiB frame number regardless of guest pages
          if (wr_go && awaddr_q == GMB_REG_FRAME) begin // RULE3 RULE4
            left_q <= left_q - 32'h1;
            frames_q <= (st_q == GMB_GROW) ? frames_q + 32'h1
                                           : frames_q - 32'h1;
            if (left_q == 32'h1) begin
              st_q <= GMB_RET; // RULE23
              used_q <= (st_q == GMB_GROW) ? 2'b01 : 2'b10;
            end
          end
        end
        GMB_RET: begin
          // no frame is ever locked, so early reuse is harmless
          if (wr_go && awaddr_q == GMB_REG_DONE) begin // RULE6 RULE7
            st_q <= GMB_IDLE;
            used_q <= 2'b00;
          end
        end
        default: st_q <= GMB_IDLE;
      endcase
    end
  end

  // report queue: hold buffer, return it on request, take new stats
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      report_held_q <= 1'b0;
      report_buf_q <= 1'b0;
      report_irq_q <= 1'b0;
      last_q <= '0;
    end else begin
      if (wr_go && awaddr_q == GMB_REG_NOTIFY && wv[1:0] == GMB_Q_REPORT
          && feat_q[GMB_FEAT_REPORT_BIT]) begin
        report_held_q <= 1'b1; // RULE11 RULE14
        report_buf_q <= 1'b0;
      end else if (wr_go && awaddr_q == GMB_REG_CTRL && wv[0]
                   && report_held_q) begin
        report_held_q <= 1'b0; // RULE12
        report_buf_q <= 1'b1;
        report_irq_q <= 1'b1;
      end else if (wr_go && awaddr_q == GMB_REG_STATUS && wv[1]) begin
        report_irq_q <= 1'b0; // RULE13
      end
      if (wr_go && awaddr_q == GMB_REG_STAT_TAG) begin
        last_q.tag <= wfix[15:0]; // RULE15 RULE17
      end
      if (wr_go && awaddr_q == GMB_REG_STAT_LO) begin
        last_q.value[31:0] <= wfix;
      end
    end
  end

  // record complete on high word; unknown tags are dropped
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 6; i++) begin
        stats_q[i] <= 64'h0;
      end
    end else if (wr_go && awaddr_q == GMB_REG_STAT_HI
                 && last_q.tag < {13'h0, GMB_NUM_TAGS}) begin
      // RULE18 RULE19 RULE16
      stats_q[last_q.tag[2:0]] <= {wfix, last_q.value[31:0]};
    end
  end

  // read port
  logic [31:0] rd;
  always_comb begin
    rd = 32'h0000_0000;
    case (s_axi_araddr)
      GMB_REG_REQ: rd = req_q;
      GMB_REG_HELD: rd = held_q;
      GMB_REG_FEAT: rd = {legacy_q, 29'h0, feat_q};
      GMB_REG_STATUS: rd = {24'h0, st_q == GMB_IDLE, report_buf_q,
                            report_held_q, req_q > held_q, // RULE2
                            req_q < held_q, used_q,
                            config_irq_q | report_irq_q};
      GMB_REG_FRAMES: rd = frames_q;
      default: begin
        if (s_axi_araddr >= GMB_REG_STAT_BASE &&
            s_axi_araddr < GMB_REG_STAT_BASE + 8'h30) begin
          rd = s_axi_araddr[2] ?
            stats_q[3'(s_axi_araddr[5:3] + 3'h0)][63:32] :
            stats_q[3'(s_axi_araddr[5:3] + 3'h0)][31:0];
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= GMB_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd;
        s_axi_rresp <= (s_axi_araddr <= GMB_REG_FRAMES ||
          (s_axi_araddr >= GMB_REG_STAT_BASE &&
           s_axi_araddr < GMB_REG_STAT_BASE + 8'h30)) ? GMB_RESP_OKAY
                                                     : GMB_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : gmb_balloon
`default_nettype wire

// ---- verification/gmb_balloon_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module gmb_balloon_chk
  import gmb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic config_irq_q,
  input wire logic report_irq_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // irq levels only move as the effect of a register write
  a_cfg_raise: assert property ($rose(config_irq_q) |-> ##[0:2] s_axi_bvalid)
    else $error("config irq rose without a write");
  a_cfg_clear: assert property ($fell(config_irq_q) |-> ##[0:2] s_axi_bvalid)
    else $error("config irq fell without a write");
  a_report_raise: assert property ($rose(report_irq_q) |-> ##[0:2] s_axi_bvalid)
    else $error("report irq rose without a write");
  // bus answers: fixed latency, held until accepted
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped");
  a_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr == 8'h30 |=> s_axi_rresp == GMB_RESP_SLVERR)
    else $error("unmapped read not refused");
  c_cfg: cover property ($rose(config_irq_q));
  c_rep: cover property ($rose(report_irq_q));
  c_err: cover property (s_axi_rvalid && s_axi_rresp == GMB_RESP_SLVERR);
endmodule : gmb_balloon_chk
bind gmb_balloon gmb_balloon_chk i_chk (.*);
`default_nettype wire

// ---- verification/gmb_drv_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module gmb_drv_model
  import gmb_pkg::*;
(
  input wire logic clk_sys,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready,
  output logic hang
);
  // idle bus at time zero; full words only
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready, hang} = '0;
    s_axi_wstrb = 4'hf;
  end
  // address and data offered together, each dropped once taken;
  // local flags track progress since nonblocking drives lag a time step
  // ready rises only once valid is seen, so the slave must hold its answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b, bb;
    int n;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
    {aw, w, b, bb} = 4'he;
    for (n = 0; aw || w || b; n++) begin
      @(posedge clk_sys);
      if (bb && s_axi_bvalid) begin
        s_axi_bready <= 1'b0;
        b = 1'b0;
      end else if (!bb && s_axi_bvalid) begin
        s_axi_bready <= 1'b1;
        bb = 1'b1;
      end
      if (aw && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        aw = 1'b0;
      end
      if (w && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        w = 1'b0;
      end
      if (n == 200) hang <= 1'b1;
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic ar, r, rr;
    int n;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    {ar, r, rr} = 3'h6;
    d = 32'h0000_0000;
    for (n = 0; ar || r; n++) begin
      @(posedge clk_sys);
      if (rr && s_axi_rvalid) begin
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        r = 1'b0;
      end else if (!rr && s_axi_rvalid) begin
        s_axi_rready <= 1'b1;
        rr = 1'b1;
      end
      if (ar && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        ar = 1'b0;
      end
      if (n == 200) hang <= 1'b1;
    end
  endtask : rd
  // notify with the count opens the descriptor, then one write per frame;
  // frame numbers are byte address over 4096
  task automatic post(input logic [1:0] q, input logic [15:0] cnt,
                      input logic [31:0] base);
    logic [31:0] fr;
    wr(GMB_REG_NOTIFY, {cnt, 14'h0, q});
    for (int i = 0; i < cnt; i++) begin
      fr = (base + i * GMB_PAGE_BYTES) / GMB_PAGE_BYTES;
      wr(GMB_REG_FRAME, fr);
    end
  endtask : post
endmodule : gmb_drv_model
`default_nettype wire

// ---- verification/gmb_balloon_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module gmb_balloon_tb;
  import gmb_pkg::*;
  logic clk_sys = 0, rstn = 0, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, hang;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, config_irq_q, report_irq_q;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, req, rnd = 32'h46d0a7bf;
  logic [31:0] lo [6], hi [6];
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [1:0] bexp = GMB_RESP_OKAY;
  logic [65:0] expq [$];
  int mismatches = 0, checks = 0;
  gmb_balloon i_dut (.*);
  gmb_drv_model i_drv (.*);
  always #5 clk_sys = ~clk_sys;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // guest order in legacy mode: each 32-bit word arrives byte reversed
  function automatic logic [31:0] bswap(input logic [31:0] v);
    return {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction : bswap
  task automatic cmp(input string n, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : cmp
  task automatic final_report;
    if (mismatches == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  // note the expectation, then read; a zero mask checks only the response code
  task automatic chk(input logic [7:0] a, input logic [31:0] m, e,
                     input logic [1:0] r = GMB_RESP_OKAY);
    expq.push_back({r, m, e});
    i_drv.rd(a, d);
  endtask : chk
  task automatic wait_used(input logic [1:0] u);
    for (int i = 0; i < 50; i++) begin
      chk(GMB_REG_STATUS, 32'h0, 32'h0);
      if (d[2:1] == u) return;
    end
    mismatches++;
    final_report();
  endtask : wait_used
  // read monitor takes the oldest note per returned beat
  always @(posedge clk_sys) if (s_axi_rvalid && s_axi_rready) begin
    cmp("rresp", {30'h0, s_axi_rresp}, {30'h0, expq[0][65:64]});
    cmp("rdata", s_axi_rdata & expq[0][63:32], expq[0][31:0]);
    void'(expq.pop_front());
  end
  // write monitor: each response against the code noted before the write
  always @(posedge clk_sys) if (s_axi_bvalid && s_axi_bready) begin
    cmp("bresp", {30'h0, s_axi_bresp}, {30'h0, bexp});
  end
  always @(posedge hang) begin
    mismatches++;
    final_report();
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk(GMB_REG_REQ, '1, GMB_REQ_RESET);
    req = (lfsr(rnd) & 32'h0000_ffff) | 32'h0000_0010;
    i_drv.wr(GMB_REG_REQ, req);
    cmp("cfg_irq", {31'h0, config_irq_q}, 32'h1);
    chk(GMB_REG_STATUS, 32'h19, 32'h11);
    i_drv.wr(GMB_REG_STATUS, 32'h1);
    cmp("cfg_irq", {31'h0, config_irq_q}, 32'h0);
    i_drv.post(GMB_Q_GROW, 16'h2, 32'h0008_0000);
    wait_used(2'b01);
    chk(GMB_REG_FRAMES, '1, 32'h2);
    i_drv.wr(GMB_REG_DONE, 32'h1);
    i_drv.wr(GMB_REG_HELD, 32'h2);
    i_drv.post(GMB_Q_SHRINK, 16'h1, 32'h0008_1000);
    wait_used(2'b10);
    chk(GMB_REG_FRAMES, '1, 32'h1);
    i_drv.wr(GMB_REG_DONE, 32'h1);
    i_drv.wr(GMB_REG_HELD, 32'h1);
    i_drv.wr(GMB_REG_REQ, 32'h0);
    chk(GMB_REG_STATUS, 32'h18, 32'h08);
    i_drv.wr(GMB_REG_FEAT, 32'h2);
    i_drv.wr(GMB_REG_NOTIFY, {30'h0, GMB_Q_REPORT});
    chk(GMB_REG_STATUS, 32'h20, 32'h20);
    i_drv.wr(GMB_REG_CTRL, 32'h1);
    cmp("rep_irq", {31'h0, report_irq_q}, 32'h1);
    chk(GMB_REG_STATUS, 32'h60, 32'h40);
    i_drv.wr(GMB_REG_STATUS, 32'h2);
    cmp("rep_irq", {31'h0, report_irq_q}, 32'h0);
    for (int t = 0; t < 6; t++) begin
      rnd = lfsr(rnd);
      lo[t] = rnd;
      rnd = lfsr(rnd);
      hi[t] = rnd;
      i_drv.wr(GMB_REG_STAT_TAG, t);
      i_drv.wr(GMB_REG_STAT_LO, lo[t]);
      i_drv.wr(GMB_REG_STAT_HI, hi[t]);
    end
    i_drv.wr(GMB_REG_NOTIFY, {30'h0, GMB_Q_REPORT});
    chk(GMB_REG_STATUS, 32'h20, 32'h20);
    for (int t = 0; t < 6; t++) begin
      chk(GMB_REG_STAT_BASE + 8'(t * 8), '1, lo[t]);
      chk(GMB_REG_STAT_BASE + 8'(t * 8 + 4), '1, hi[t]);
    end
    i_drv.wr(GMB_REG_FEAT, 32'h8000_0002);
    i_drv.wr(GMB_REG_HELD, 32'h0000_0003);
    chk(GMB_REG_HELD, '1, 32'h0000_0003);
    i_drv.wr(GMB_REG_STAT_TAG, 32'h0200_0000);
    i_drv.wr(GMB_REG_STAT_LO, lo[0]);
    i_drv.wr(GMB_REG_STAT_HI, hi[0]);
    chk(GMB_REG_STAT_BASE + 8'h10, '1, bswap(lo[0]));
    chk(GMB_REG_STAT_BASE + 8'h14, '1, bswap(hi[0]));
    bexp = GMB_RESP_SLVERR;
    i_drv.wr(8'h30, rnd);
    chk(8'h30, 32'h0, 32'h0, GMB_RESP_SLVERR);
    repeat (4) @(posedge clk_sys);
    final_report();
  end
endmodule : gmb_balloon_tb
`default_nettype wire
